/* File: src/odcd_top.sv */
// Purpose: Display control command decoder behind an APB slave
// Assumes: Host writes opcodes to the command register, bytes to data
// Notes: Settings feed the refresh and RAM access logic
//
// Contract
// - Opcode 00h unlocks the later gray table load command.
// - 15h takes column start and end, reset 0 and 119, range 0-119; the code does not limit them and keeps any 7-bit value, 0-127.
// - 75h takes row start and end, reset 0 and 127, range 0-127.
// - After 5Ch data bytes are pixel data stored into display memory.
// - After 5Dh the host may read display memory contents.
// - A1h loads the 7-bit memory row shown at display top.
// - Display start line returns to zero on reset.
// - A2h loads a 7-bit vertical offset in common lines, reset zero.
// - A4h forces every pixel to gray level 0.
// - A5h forces every pixel to gray level 15.
// - A6h shows memory unchanged; this normal mode is the reset mode.
// - A7h inverts each gray level, n becomes 15 minus n.
// - A8h enables partial mode with start row and end row parameters.
// - A9h leaves partial mode and shows all rows again.
`timescale 1ns/1ps
module odcd_top import odcd_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pix_valid,
	input wire logic pix_ready,
	output logic [7:0] pix_data,
	output logic ram_rd_req,
	input wire logic ram_rd_valid,
	input wire logic [7:0] ram_rd_data,
	output logic [6:0] col_start,
	output logic [6:0] col_end,
	output logic [6:0] row_start,
	output logic [6:0] row_end,
	output logic [6:0] start_line,
	output logic [6:0] vert_offset,
	output logic [7:0] remap_field,
	output logic dual_common_line,
	output logic [3:0] disp_mode,
	output logic partial_on,
	output logic [6:0] part_start,
	output logic [6:0] part_end,
	output logic gray_unlock,
	output logic gray_load,
	input wire logic [3:0] gray_level_in,
	input wire logic gray_level_in_valid,
	output logic [3:0] gray_level_out,
	output logic gray_level_out_valid
);
	odcd_state_t state;
	logic [7:0] opcode;
	logic [7:0] param_hold;
	logic [7:0] byte_in;
	logic act;
	logic wr_cmd;
	logic wr_dat;
	logic access;
	logic mapped;
	logic rd_pending;
	logic fifo_in_ready;
	logic [4:0] fifo_level;
	logic data_stall;
	logic ram_read;
	logic [31:0] read_mux;

	// Bus phase decode: effects happen at the completing edge
	assign act = psel & penable & pready;
	assign access = psel & penable & ~pready;
	assign byte_in = pwdata[7:0];
	// Opcodes come from the command register, parameters from data
	assign wr_cmd = act & pwrite & (paddr == OFF_CMD) & ~pslverr;
	assign wr_dat = act & pwrite & (paddr == OFF_DATA) & ~pslverr;
	assign data_stall = pwrite & (paddr == OFF_DATA) &
		(state == ST_WRITE) & ~fifo_in_ready;
	assign ram_read = ~pwrite & (paddr == OFF_RDATA) & (state == ST_READ);

	always_comb begin
		unique case (paddr)
			OFF_CMD, OFF_DATA, OFF_RDATA, OFF_STATUS, OFF_COLWIN,
			OFF_ROWWIN, OFF_SCROLL, OFF_PART, OFF_REMAP: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (paddr)
			OFF_STATUS: read_mux = {13'h0000, gray_unlock, partial_on,
				fifo_level, disp_mode, opcode[2:0], state};
			OFF_COLWIN: read_mux = {17'h00000, col_end, 1'b0, col_start};
			OFF_ROWWIN: read_mux = {17'h00000, row_end, 1'b0, row_start};
			OFF_SCROLL: read_mux = {17'h00000, vert_offset, 1'b0,
				start_line};
			OFF_PART: read_mux = {16'h0000, 1'b0, part_end, 1'b0,
				part_start};
			OFF_REMAP: read_mux = {23'h000000, dual_common_line,
				remap_field};
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// APB answer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (pready) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (access) begin
			if (!mapped) begin
				pready <= 1'b1;
				pslverr <= 1'b1;
				prdata <= 32'h0000_0000;
			end else if (data_stall) begin
				pready <= 1'b0;
			end else if (ram_read) begin
				if (rd_pending & ram_rd_valid) begin
					pready <= 1'b1;
					prdata <= {24'h000000, ram_rd_data};
				end
			end else begin
				pready <= 1'b1;
				prdata <= read_mux;
			end
		end
	end

	// Memory read request toward the RAM access logic
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ram_rd_req <= 1'b0;
			rd_pending <= 1'b0;
		end else begin
			ram_rd_req <= access & ram_read & ~rd_pending & ~ram_rd_req;
			if (ram_rd_req)
				rd_pending <= 1'b1;
			else if (rd_pending & ram_rd_valid)
				rd_pending <= 1'b0;
		end
	end

	// Command sequencer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			opcode <= OP_UNLOCK;
			param_hold <= 8'h00;
		end else if (wr_cmd) begin
			opcode <= byte_in;
			unique case (byte_in)
				OP_COLWIN, OP_ROWWIN, OP_REMAP, OP_PARTON,
				OP_START, OP_OFFSET: state <= ST_PARAM1;
				OP_WRRAM: state <= ST_WRITE;
				OP_RDRAM: state <= ST_READ;
				default: state <= ST_IDLE;
			endcase
		end else if (wr_dat) begin
			unique case (state)
				ST_PARAM1: begin
					param_hold <= byte_in;
					if (opcode == OP_START || opcode == OP_OFFSET)
						state <= ST_IDLE;
					else
						state <= ST_PARAM2;
				end
				ST_PARAM2: state <= ST_IDLE;
				ST_WRITE: state <= ST_WRITE;
				ST_READ: state <= ST_READ;
				ST_IDLE: state <= ST_IDLE;
			endcase
		end
	end

	// Address windows, committed on the second parameter
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			col_start <= RST_COL_START;
			col_end <= RST_COL_END;
			row_start <= RST_ROW_START;
			row_end <= RST_ROW_END;
		end else if (wr_dat && state == ST_PARAM2) begin
			if (opcode == OP_COLWIN) begin
				col_start <= param_hold[6:0];
				col_end <= byte_in[6:0];
			end
			if (opcode == OP_ROWWIN) begin
				row_start <= param_hold[6:0];
				row_end <= byte_in[6:0];
			end
		end
	end

	// Start line and vertical offset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			start_line <= RST_START_LINE;
			vert_offset <= RST_OFFSET;
		end else if (wr_dat && state == ST_PARAM1) begin
			if (opcode == OP_START)
				start_line <= byte_in[6:0];
			if (opcode == OP_OFFSET)
				vert_offset <= byte_in[6:0];
		end
	end

	// Remap field and dual line bit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			remap_field <= RST_REMAP;
			dual_common_line <= 1'b0;
		end else if (wr_dat && state == ST_PARAM2 && opcode == OP_REMAP) begin
			remap_field <= param_hold;
			dual_common_line <= byte_in[REMAP_B_BIT];
		end
	end

	// Display mode
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			disp_mode <= MODE_NORMAL;
		end else if (wr_cmd) begin
			unique case (byte_in)
				OP_ALLOFF: disp_mode <= MODE_ALLOFF;
				OP_ALLON: disp_mode <= MODE_ALLON;
				OP_NORMAL: disp_mode <= MODE_NORMAL;
				OP_INVERSE: disp_mode <= MODE_INVERSE;
				default: disp_mode <= disp_mode;
			endcase
		end
	end

	// Partial display area
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			partial_on <= 1'b0;
			part_start <= RST_PART_START;
			part_end <= RST_PART_END;
		end else if (wr_cmd && byte_in == OP_PARTOFF) begin
			partial_on <= 1'b0;
		end else if (wr_dat && state == ST_PARAM2 && opcode == OP_PARTON) begin
			partial_on <= 1'b1;
			part_start <= param_hold[6:0];
			part_end <= byte_in[6:0];
		end
	end

	// Gray table unlock, consumed by the next opcode
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gray_unlock <= 1'b0;
			gray_load <= 1'b0;
		end else begin
			gray_load <= 1'b0;
			if (wr_cmd) begin
				gray_unlock <= (byte_in == OP_UNLOCK);
				if (byte_in == OP_GRAYLOAD && gray_unlock)
					gray_load <= 1'b1;
			end
		end
	end

	// Pixel bytes into display memory through the FIFO
	odcd_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(wr_dat & (state == ST_WRITE)),
		.in_ready(fifo_in_ready),
		.in_data(byte_in),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(pix_data),
		.level(fifo_level)
	);

	odcd_gray_map u_map (
		.mclk(mclk),
		.reset(reset),
		.mode(disp_mode),
		.gray_level_in(gray_level_in),
		.gray_level_in_valid(gray_level_in_valid),
		.gray_level_out(gray_level_out),
		.gray_level_out_valid(gray_level_out_valid)
	);
endmodule : odcd_top

/* File: src/odcd_pkg.sv */
// Purpose: Shared constants for the display command decoder
// Assumes: Byte-wide command and parameter stream from an APB front end
// Notes: Register offsets are byte addresses on a 32-bit APB bus
package odcd_pkg;
	// Register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_RDATA = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_COLWIN = 8'h10;
	localparam logic [7:0] OFF_ROWWIN = 8'h14;
	localparam logic [7:0] OFF_SCROLL = 8'h18;
	localparam logic [7:0] OFF_PART = 8'h1c;
	localparam logic [7:0] OFF_REMAP = 8'h20;
	// Opcodes
	localparam logic [7:0] OP_UNLOCK = 8'h00;
	localparam logic [7:0] OP_COLWIN = 8'h15;
	localparam logic [7:0] OP_WRRAM = 8'h5c;
	localparam logic [7:0] OP_RDRAM = 8'h5d;
	localparam logic [7:0] OP_ROWWIN = 8'h75;
	localparam logic [7:0] OP_REMAP = 8'ha0;
	localparam logic [7:0] OP_START = 8'ha1;
	localparam logic [7:0] OP_OFFSET = 8'ha2;
	localparam logic [7:0] OP_ALLOFF = 8'ha4;
	localparam logic [7:0] OP_ALLON = 8'ha5;
	localparam logic [7:0] OP_NORMAL = 8'ha6;
	localparam logic [7:0] OP_INVERSE = 8'ha7;
	localparam logic [7:0] OP_PARTON = 8'ha8;
	localparam logic [7:0] OP_PARTOFF = 8'ha9;
	localparam logic [7:0] OP_GRAYLOAD = 8'hb8;
	// Reset values
	localparam logic [6:0] RST_COL_START = 7'h00;
	localparam logic [6:0] RST_COL_END = 7'h77;
	localparam logic [6:0] RST_ROW_START = 7'h00;
	localparam logic [6:0] RST_ROW_END = 7'h7f;
	localparam logic [6:0] RST_START_LINE = 7'h00;
	localparam logic [6:0] RST_OFFSET = 7'h00;
	localparam logic [6:0] RST_PART_START = 7'h00;
	localparam logic [6:0] RST_PART_END = 7'h7f;
	localparam logic [7:0] RST_REMAP = 8'h00;
	// Field layout
	localparam int REMAP_B_BIT = 4;
	localparam logic [3:0] GRAY_MAX = 4'hf;
	localparam logic [3:0] GRAY_MIN = 4'h0;
	// Buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;
	// Display modes
	typedef enum logic [3:0] {
		MODE_ALLOFF = 4'h1,
		MODE_ALLON = 4'h2,
		MODE_NORMAL = 4'h4,
		MODE_INVERSE = 4'h8
	} odcd_mode_t;
	// Decoder states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PARAM1 = 5'h02,
		ST_PARAM2 = 5'h04,
		ST_WRITE = 5'h08,
		ST_READ = 5'h10
	} odcd_state_t;
endpackage : odcd_pkg

/* File: src/odcd_fifo.sv */
// Purpose: Pixel byte FIFO with valid and ready on both sides
// Assumes: Single clock
// Notes: Full and empty are registered flags
`timescale 1ns/1ps
module odcd_fifo import odcd_pkg::*; #(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic full;
	logic push;
	logic pop;
	logic [AW:0] next_level;

	assign push = in_valid & ~full;
	assign pop = out_ready & out_valid;
	assign in_ready = ~full;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_level = level;
		if (push & ~pop)
			next_level = level + 1'b1;
		else if (pop & ~push)
			next_level = level - 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			full <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			level <= next_level;
			full <= (next_level == (AW+1)'(DEPTH));
			out_valid <= (next_level != '0);
		end
	end
endmodule : odcd_fifo

/* File: src/odcd_gray_map.sv */
// Purpose: Applies the display mode to each pixel gray level
// Assumes: One pixel per cycle from the refresh logic
// Notes: Output is registered, one cycle of latency
`timescale 1ns/1ps
module odcd_gray_map import odcd_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] mode,
	input wire logic [3:0] gray_level_in,
	input wire logic gray_level_in_valid,
	output logic [3:0] gray_level_out,
	output logic gray_level_out_valid
);
	logic [3:0] next_level;

	always_comb begin
		next_level = gray_level_in;
		unique case (mode)
			MODE_ALLOFF: next_level = GRAY_MIN;
			MODE_ALLON: next_level = GRAY_MAX;
			MODE_NORMAL: next_level = gray_level_in;
			MODE_INVERSE: next_level = GRAY_MAX - gray_level_in;
			default: next_level = gray_level_in;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gray_level_out <= GRAY_MIN;
			gray_level_out_valid <= 1'b0;
		end else begin
			gray_level_out <= next_level;
			gray_level_out_valid <= gray_level_in_valid;
		end
	end
endmodule : odcd_gray_map

/* File: sim/odcd_chk.sv */
// Purpose: Port checker for the command decoder
// Assumes: One clock, async high reset
// Notes: Bound to odcd_top
`timescale 1ns/1ps
module odcd_chk import odcd_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pix_valid,
	input wire logic ram_rd_req,
	input wire logic partial_on,
	input wire logic gray_load,
	input wire logic [3:0] disp_mode,
	input wire logic [3:0] gray_level_in,
	input wire logic gray_level_in_valid,
	input wire logic [3:0] gray_level_out
);
	logic wr_cmd;
	logic wr_dat;
	logic gin;
	assign wr_cmd = psel && penable && pready && pwrite && paddr == OFF_CMD;
	assign wr_dat = psel && penable && pready && pwrite && paddr == OFF_DATA;
	assign gin = gray_level_in_valid;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_gray_off: assert property (
		gin && disp_mode == MODE_ALLOFF |=> gray_level_out == GRAY_MIN)
		else $error("all-off level wrong");
	chk_gray_on: assert property (
		gin && disp_mode == MODE_ALLON |=> gray_level_out == GRAY_MAX)
		else $error("all-on level wrong");
	chk_gray_normal: assert property (
		gin && disp_mode == MODE_NORMAL |=> gray_level_out == $past(gray_level_in))
		else $error("normal level wrong");
	chk_gray_inverse: assert property (
		gin && disp_mode == MODE_INVERSE
		|=> gray_level_out == GRAY_MAX - $past(gray_level_in))
		else $error("inverse level wrong");
	chk_mode_cause: assert property (
		disp_mode != $past(disp_mode)
		|-> $past(wr_cmd && pwdata[7:2] == 6'b101001))
		else $error("mode changed without command");
	chk_part_on: assert property (
		$rose(partial_on) |-> $past(wr_dat))
		else $error("partial on without parameter");
	chk_part_off: assert property (
		$fell(partial_on) |-> $past(wr_cmd && pwdata[7:0] == OP_PARTOFF))
		else $error("partial off without command");
	chk_load_pulse: assert property (
		gray_load |-> ($past(wr_cmd && pwdata[7:0] == OP_GRAYLOAD)
		|| $past(wr_cmd && pwdata[7:0] == OP_GRAYLOAD, 2)) ##1 !gray_load)
		else $error("table load pulse wrong");
	chk_pix_push: assert property (
		$rose(pix_valid) |-> $past(wr_dat))
		else $error("pixel without data write");
	chk_ram_req: assert property (
		ram_rd_req |-> $past(psel && penable && !pwrite && paddr == OFF_RDATA)
		##1 !ram_rd_req)
		else $error("memory read request wrong");
endmodule : odcd_chk
bind odcd_top odcd_chk u_chk (.mclk(mclk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pix_valid(pix_valid), .ram_rd_req(ram_rd_req),
	.partial_on(partial_on), .gray_load(gray_load), .disp_mode(disp_mode),
	.gray_level_in(gray_level_in), .gray_level_in_valid(gray_level_in_valid),
	.gray_level_out(gray_level_out));

/* File: sim/odcd_far_model.sv */
// Purpose: Memory and pixel sink beyond the decoder
// Assumes: dly sets read answer latency
// Notes: Read data is inverted once the answer has gone
`timescale 1ns/1ps
module odcd_far_model (
	input wire logic mclk,
	input wire logic ram_rd_req,
	output logic ram_rd_valid,
	output logic [7:0] ram_rd_data,
	input wire logic pix_valid,
	input wire logic [7:0] pix_data,
	input wire logic stall,
	output logic pix_ready
);
	logic [7:0] got[$];
	logic [7:0] n = 8'ha0;
	int dly = 3;
	initial begin
		ram_rd_valid = 1'b0;
		ram_rd_data = 8'h5a;
	end
	assign pix_ready = !stall;
	always @(posedge mclk) if (pix_valid && pix_ready) got.push_back(pix_data);
	always @(posedge mclk) if (ram_rd_req) begin
		repeat (dly) @(posedge mclk);
		ram_rd_valid <= 1'b1;
		ram_rd_data <= n;
		@(posedge mclk);
		ram_rd_valid <= 1'b0;
		ram_rd_data <= ~n;
		n <= n + 8'h01;
	end
endmodule : odcd_far_model

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the command decoder
// Assumes: APB master tasks and far-side model
// Notes: Counts checks and failures
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb import odcd_pkg::*; ;
	logic mclk, reset, psel, penable, pwrite, stall, err;
	logic [7:0] paddr, pix_data, ram_rd_data, remap_field;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, pix_valid, pix_ready, ram_rd_req, ram_rd_valid;
	logic [6:0] col_start, col_end, row_start, row_end, start_line;
	logic [6:0] vert_offset, part_start, part_end;
	logic dual_common_line, partial_on, gray_unlock, gray_load;
	logic [3:0] disp_mode, gray_level_in, gray_level_out;
	logic gray_level_in_valid, gray_level_out_valid;
	int failures = 0, checks = 0, loads = 0, i;
	time t0;
	logic [3:0] gexp [4] = '{4'h0, 4'hf, 4'h3, 4'hc};
	odcd_top uut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pix_valid, .pix_ready, .pix_data,
		.ram_rd_req, .ram_rd_valid, .ram_rd_data, .col_start, .col_end,
		.row_start, .row_end, .start_line, .vert_offset, .remap_field,
		.dual_common_line, .disp_mode, .partial_on, .part_start, .part_end,
		.gray_unlock, .gray_load, .gray_level_in, .gray_level_in_valid,
		.gray_level_out, .gray_level_out_valid);
	odcd_far_model far (.mclk, .ram_rd_req, .ram_rd_valid, .ram_rd_data,
		.pix_valid, .pix_data, .stall, .pix_ready);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) if (gray_load === 1'b1) loads++;
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1 && ++n < 400);
		if (pready !== 1'b1) begin
			failures++;
			wrap_up;
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic cmd(input logic [7:0] op);
		apb(1'b1, OFF_CMD, {24'h0, op});
	endtask : cmd
	task automatic dat(input logic [7:0] b);
		apb(1'b1, OFF_DATA, {24'h0, b});
	endtask : dat
	task automatic rst;
		reset <= 1'b1;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
	endtask : rst
	task automatic wrap_up;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#20us;
		failures++;
		wrap_up;
	end
	initial begin
		{reset, psel, penable, pwrite, stall, gray_level_in_valid} = 6'h20;
		{paddr, pwdata, gray_level_in} = '0;
		rst;
		`CHK(col_end, 7'h77)
		`CHK(row_end, 7'h7f)
		`CHK(start_line, 7'h00)
		`CHK(vert_offset, 7'h00)
		`CHK(disp_mode, 4'h4)
		$display("test reset done");
		cmd(OP_COLWIN);
		dat(8'h85);
		dat(8'hf7);
		apb(1'b0, OFF_COLWIN, 32'h0);
		`CHK(r, 32'h7705)
		cmd(OP_ROWWIN);
		dat(8'h10);
		dat(8'hff);
		cmd(OP_ROWWIN);
		dat(8'h01);
		cmd(OP_NORMAL);
		apb(1'b0, OFF_ROWWIN, 32'h0);
		`CHK(r, 32'h7f10)
		cmd(OP_START);
		dat(8'hc0);
		cmd(OP_OFFSET);
		dat(8'h7f);
		apb(1'b0, OFF_SCROLL, 32'h0);
		`CHK(r, 32'h7f40)
		$display("test windows done");
		for (i = 0; i < 4; i++) begin
			cmd(8'(OP_ALLOFF + i));
			`CHK(disp_mode, 4'(1 << i))
			gray_level_in <= 4'h3;
			gray_level_in_valid <= 1'b1;
			@(posedge mclk);
			gray_level_in_valid <= 1'b0;
			#1 `CHK(gray_level_out, gexp[i])
			`CHK(gray_level_out_valid, 1'b1)
			@(posedge mclk);
		end
		$display("test modes done");
		cmd(OP_PARTON);
		dat(8'h0a);
		`CHK(partial_on, 1'b0)
		dat(8'h94);
		`CHK(partial_on, 1'b1)
		apb(1'b0, OFF_PART, 32'h0);
		`CHK(r, 32'h140a)
		cmd(OP_PARTOFF);
		`CHK(partial_on, 1'b0)
		$display("test partial done");
		cmd(OP_GRAYLOAD);
		repeat (3) @(posedge mclk);
		`CHK(loads, 0)
		cmd(OP_UNLOCK);
		`CHK(gray_unlock, 1'b1)
		cmd(OP_GRAYLOAD);
		repeat (3) @(posedge mclk);
		`CHK(loads, 1)
		cmd(OP_REMAP);
		dat(8'h5a);
		dat(8'h11);
		`CHK(remap_field, 8'h5a)
		`CHK(dual_common_line, 1'b1)
		$display("test unlock remap done");
		dat(8'h77);
		stall <= 1'b1;
		cmd(OP_WRRAM);
		for (i = 0; i < 16; i++) dat(8'(i));
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK(r[16:12], 5'h10)
		t0 = $time;
		fork
			dat(8'h10);
			begin
				repeat (20) @(posedge mclk);
				stall <= 1'b0;
			end
		join
		`CHK($time - t0 > 100, 1'b1)
		repeat (40) @(posedge mclk);
		`CHK(far.got.size(), 17)
		for (i = 0; i < 17; i++) `CHK(far.got[i], 8'(i))
		$display("test pixels done");
		cmd(OP_RDRAM);
		far.dly = 0;
		apb(1'b0, OFF_RDATA, 32'h0);
		`CHK(r[7:0], 8'ha0)
		far.dly = 6;
		apb(1'b0, OFF_RDATA, 32'h0);
		`CHK(r[7:0], 8'ha1)
		apb(1'b1, 8'h40, 32'h0);
		`CHK(err, 1'b1)
		$display("test read done");
		rst;
		`CHK(start_line, 7'h00)
		`CHK(vert_offset, 7'h00)
		`CHK(col_end, 7'h77)
		`CHK(col_start, 7'h00)
		`CHK(row_start, 7'h00)
		`CHK(part_end, 7'h7f)
		`CHK(disp_mode, MODE_NORMAL)
		$display("test second reset done");
		wrap_up;
	end
endmodule : tb
